// file: esd_defs.svh
// Constants of the encoder speed and diagnostic object block.
`ifndef ESD_DEFS_SVH
`define ESD_DEFS_SVH
// ----------------------------------------------------------------
// Object indices and entry counts
// ----------------------------------------------------------------
`define ESD_IDX_SPEED_CTRL  16'h3010
`define ESD_IDX_SPEED_VAL   16'h3011
`define ESD_IDX_ACCEL_CTRL  16'h3020
`define ESD_IDX_ACCEL_VAL   16'h3021
`define ESD_IDX_COMPAT      16'h3030
`define ESD_IDX_LIFE        16'h3040
`define ESD_IDX_TSTAMP      16'h3050
`define ESD_IDX_BOOT        16'h4000
`define ESD_IDX_PPR         16'h4010
`define ESD_SUB_COUNT       32'h0000_0002
// ----------------------------------------------------------------
// Reset values, signatures and limits
// ----------------------------------------------------------------
`define ESD_UNIT_OFF        8'h00
`define ESD_UNIT_STEPS      8'h01
`define ESD_UNIT_RPM        8'h02
`define ESD_FILT_MAX        8'h02
`define ESD_PPR_RST         16'h0400
`define ESD_PPR_MAX         16'h4000
`define ESD_UNLOCK_SIG      32'h4d42_5954
`define ESD_COMPAT_SIG      24'h42_434d
// Bootloader security code: value is arbitrary, replace per product.
`define ESD_BOOT_CODE       32'h5a5a_0001
`define ESD_BOOT_NODE       7'h01
`define ESD_BOOT_BITRATE    3'h3
// ----------------------------------------------------------------
// SDO framing
// ----------------------------------------------------------------
`define ESD_COB_RX          11'h600
`define ESD_COB_TX          11'h580
`define ESD_DLC             4'h8
`define ESD_CMD_UPLOAD      8'h40
`define ESD_RSP_DOWNLOAD    8'h60
`define ESD_RSP_UP1         8'h4f
`define ESD_RSP_UP2         8'h4b
`define ESD_RSP_UP4         8'h43
`define ESD_RSP_ABORT       8'h80
`define ESD_AB_NO_OBJ       32'h0602_0000
`define ESD_AB_NO_SUB       32'h0609_0011
`define ESD_AB_RD_ONLY      32'h0601_0002
`define ESD_AB_WR_ONLY      32'h0601_0001
`define ESD_AB_RANGE        32'h0609_0030
`define ESD_AB_CMD          32'h0504_0001
`define ESD_AB_STORE        32'h0800_0020
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ESD_CLK_PERIOD_NS   25
`define ESD_TS_TICK_NS      1000
`define ESD_TS_TICK_CYC     (`ESD_TS_TICK_NS / `ESD_CLK_PERIOD_NS)
`define ESD_SPD_SAMPLE_HZ   1000
`define ESD_RPM_FACTOR      60
`endif

// file: esd_pkg.sv
// Types shared by the encoder speed and diagnostic object block.
package esd_pkg;
  typedef struct packed {
    logic [10:0]     id;
    logic [3:0]      dlc;
    logic [7:0][7:0] data;
  } esd_frame_type;

  typedef enum logic [0:0] {
    ESD_DIV_IDLE,
    ESD_DIV_RUN
  } esd_div_state_type;

  typedef struct packed {
    logic [7:0]        speed_unit;
    logic [7:0]        speed_filt;
    logic [7:0]        acc_en;
    logic [7:0]        acc_mode;
    logic [31:0]       unlock_sig;
    logic [31:0]       compat_mode;
    logic              unlocked;
    logic              legacy;
    logic              boot;
    logic              erase_req;
    logic              reset_req;
    logic [15:0]       ppr_set;
    logic [15:0]       ppr_act;
    logic [31:0]       life;
    logic [31:0]       tstamp;
    logic [31:0]       us_cnt;
    logic [5:0]        us_div;
    logic [31:0]       last_pos;
    logic              have_pos;
    logic [47:0]       sum;
    logic [9:0]        ptr;
    logic [10:0]       fill;
    logic [31:0]       speed;
    esd_div_state_type div_st;
    logic [63:0]       div_num;
    logic [63:0]       div_quo;
    logic [43:0]       div_rem;
    logic [42:0]       div_den;
    logic [5:0]        div_cnt;
    logic              div_neg;
    logic              tx_valid;
    esd_frame_type     tx_frame;
  } esd_state_type;
endpackage

// file: esd_objects.sv
// Speed, compatibility, diagnostic, bootloader and pulse-rate objects reached by SDO.
`timescale 1ns/1ps
`include "esd_defs.svh"

// Overview of operation
// - Speed unit resets to zero, measurement off.
// - Unit 0 off, 1 steps/s, 2 rpm.
// - Moving average over 10, 100, 1000 samples.
// - Signed 32-bit read-only speed, never restored.
// - Acceleration entries accessible, no acceleration output.
// - Unlock signature must precede compatibility write.
// - Compatibility word: signature plus mode byte.
// - Legacy mode aborts newer objects: nonexistent.
// - Download frame 600h+node, DLC 8, 22h.
// - Life counter cleared, increments, wraps.
// - Life counter follows measurement, not CAN.
// - Microsecond time stamp captured per measurement.
// - Correct boot code requests erase and reset in the same cycle.
// - Bootloader uses node 1, 125 kbit/s.
// - Bootloader mode: every object aborted as nonexistent, no encoding.
// - Pulses per revolution, default 1024, max 16384.
// - New pulse setting applies after NMT reset.
module esd_objects (
  // Clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_n_i,
  // Node configuration and network management
  input  wire logic [6:0]            node_id_i,
  input  wire logic                  nmt_reset_i,
  // Received SDO request frames
  input  wire logic                  rx_valid_i,
  input  wire esd_pkg::esd_frame_type rx_frame_i,
  output logic                       rx_ready_o,
  // Transmitted SDO response frames
  output logic                       tx_valid_o,
  output esd_pkg::esd_frame_type     tx_frame_o,
  input  wire logic                  tx_ready_i,
  // Position measurement process
  input  wire logic                  pos_valid_i,
  input  wire logic [31:0]           pos_value_i,
  input  wire logic [31:0]           steps_per_rev_i,
  // Process values
  output logic [31:0]                speed_value_o,
  output logic [31:0]                life_count_o,
  output logic [31:0]                time_stamp_o,
  output logic [15:0]                pulses_per_rev_o,
  output logic                       legacy_compat_mode_o,
  // Bootloader control
  output logic                       boot_active_o,
  output logic                       encoder_run_o,
  output logic                       erase_req_o,
  output logic                       reset_req_o,
  output logic [6:0]                 boot_node_id_o,
  output logic [2:0]                 boot_bitrate_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [10:0] filt_len(input logic [7:0] sel);
    case (sel)
      8'h00:   filt_len = 11'd10;
      8'h01:   filt_len = 11'd100;
      8'h02:   filt_len = 11'd1000;
      default: filt_len = 11'd10;
    endcase
  endfunction

  function automatic esd_pkg::esd_frame_type sdo_frame(
    input logic [6:0]  node,
    input logic [7:0]  cmd,
    input logic [15:0] idx,
    input logic [7:0]  sub,
    input logic [31:0] pay);
    esd_pkg::esd_frame_type f;
    f.id      = `ESD_COB_TX + {4'h0, node};
    f.dlc     = `ESD_DLC;
    f.data[0] = cmd;
    f.data[1] = idx[7:0];
    f.data[2] = idx[15:8];
    f.data[3] = sub;
    f.data[4] = pay[7:0];
    f.data[5] = pay[15:8];
    f.data[6] = pay[23:16];
    f.data[7] = pay[31:24];
    sdo_frame = f;
  endfunction

  // ----------------------------------------------------------------
  // State and history memory
  // ----------------------------------------------------------------
  esd_pkg::esd_state_type q;
  esd_pkg::esd_state_type d;

  // The speed history is too large for flops in the state struct.
  logic [31:0] hist_mem [0:1023];
  logic        hist_we;
  logic [31:0] hist_old;

  // Request fields.
  logic [7:0]  rx_cmd;
  logic [15:0] rx_idx;
  logic [7:0]  rx_sub;
  logic [31:0] rx_wd;
  logic        rx_take;

  // Object decode results.
  logic        ob_exists;
  logic        ob_sub_ok;
  logic        ob_rd;
  logic        ob_wr;
  logic [1:0]  ob_size;
  logic [31:0] ob_val;
  logic [31:0] ab_code;

  // Speed path temporaries.
  logic        spd_en;
  logic [10:0] len;
  logic [31:0] delta;
  logic [47:0] new_sum;
  logic [47:0] mag;
  logic [15:0] scale;
  logic [43:0] rem_sh;
  logic        qbit;
  logic [63:0] quo_fin;
  logic [31:0] sat_mag;

  assign rx_cmd  = rx_frame_i.data[0];
  assign rx_idx  = {rx_frame_i.data[2], rx_frame_i.data[1]};
  assign rx_sub  = rx_frame_i.data[3];
  assign rx_wd   = {rx_frame_i.data[7], rx_frame_i.data[6],
                    rx_frame_i.data[5], rx_frame_i.data[4]};
  assign rx_ready_o = !q.tx_valid;
  assign rx_take = rx_valid_i && rx_ready_o
                   && rx_frame_i.id == `ESD_COB_RX + {4'h0, node_id_i}
                   && rx_frame_i.dlc == `ESD_DLC;

  // Reserved unit codes are treated like a disabled measurement.
  assign spd_en  = q.speed_unit == `ESD_UNIT_STEPS
                   || q.speed_unit == `ESD_UNIT_RPM;
  assign len     = filt_len(q.speed_filt);
  assign hist_old = (q.fill == len) ? hist_mem[q.ptr] : 32'h0000_0000;
  assign hist_we = pos_valid_i && !q.boot && spd_en && q.have_pos;

  always_ff @(posedge sys_clk_i) begin
    if (hist_we) begin
      hist_mem[q.ptr] <= delta;
    end
  end

  // ----------------------------------------------------------------
  // Object dictionary decode
  // ----------------------------------------------------------------
  always_comb begin
    ob_exists = 1'b1;
    ob_sub_ok = rx_sub == 8'h00;
    ob_rd     = 1'b1;
    ob_wr     = 1'b0;
    ob_size   = 2'd2;
    ob_val    = 32'h0000_0000;
    case (rx_idx)
      `ESD_IDX_SPEED_CTRL, `ESD_IDX_ACCEL_CTRL, `ESD_IDX_COMPAT: begin
        ob_sub_ok = rx_sub <= 8'h02;
        ob_wr     = rx_sub != 8'h00;
        ob_size   = (rx_idx == `ESD_IDX_COMPAT && rx_sub != 8'h00) ? 2'd2 : 2'd0;
        case ({rx_idx[5:4], rx_sub[1:0]})
          4'b0101: ob_val = {24'h0, q.speed_unit};
          4'b0110: ob_val = {24'h0, q.speed_filt};
          4'b1001: ob_val = {24'h0, q.acc_en};
          4'b1010: ob_val = {24'h0, q.acc_mode};
          4'b1101: ob_val = q.unlock_sig;
          4'b1110: ob_val = q.compat_mode;
          default: ob_val = `ESD_SUB_COUNT;
        endcase
      end
      `ESD_IDX_SPEED_VAL: begin
        ob_val = q.speed;
      end
      `ESD_IDX_ACCEL_VAL: begin
        ob_val = 32'h0000_0000;
      end
      `ESD_IDX_LIFE: begin
        ob_exists = !q.legacy;
        ob_val    = q.life;
      end
      `ESD_IDX_TSTAMP: begin
        ob_exists = !q.legacy;
        ob_val    = q.tstamp;
      end
      `ESD_IDX_BOOT: begin
        ob_rd = 1'b0;
        ob_wr = 1'b1;
      end
      `ESD_IDX_PPR: begin
        ob_exists = !q.legacy;
        ob_wr     = 1'b1;
        ob_size   = 2'd1;
        ob_val    = {16'h0, q.ppr_set};
      end
      default: begin
        ob_exists = 1'b0;
      end
    endcase
    if (q.boot) begin
      ob_exists = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d         = q;
    d.erase_req = 1'b0;
    d.reset_req = 1'b0;
    ab_code   = 32'h0000_0000;
    delta     = pos_value_i - q.last_pos;
    new_sum   = q.sum + {{16{delta[31]}}, delta} - {{16{hist_old[31]}}, hist_old};
    mag       = new_sum[47] ? 48'(-new_sum) : new_sum;
    scale     = (q.speed_unit == `ESD_UNIT_RPM)
                ? 16'(`ESD_SPD_SAMPLE_HZ * `ESD_RPM_FACTOR)
                : 16'(`ESD_SPD_SAMPLE_HZ);
    rem_sh    = {q.div_rem[42:0], q.div_num[63]};
    qbit      = rem_sh >= {1'b0, q.div_den};
    quo_fin   = {q.div_quo[62:0], qbit};
    sat_mag   = (quo_fin > 64'h0000_0000_7fff_ffff) ? 32'h7fff_ffff : quo_fin[31:0];

    // Free-running microsecond base for the time stamp.
    if (q.us_div == 6'(`ESD_TS_TICK_CYC - 1)) begin
      d.us_div = 6'h00;
      d.us_cnt = q.us_cnt + 32'h0000_0001;
    end else begin
      d.us_div = q.us_div + 6'h01;
    end

    if (q.tx_valid && tx_ready_i) begin
      d.tx_valid = 1'b0;
    end

    if (nmt_reset_i) begin
      d.ppr_act = q.ppr_set;
    end

    // Divider: a new sample restarts it, so the latest average wins.
    if (q.div_st == esd_pkg::ESD_DIV_RUN) begin
      d.div_rem = qbit ? rem_sh - {1'b0, q.div_den} : rem_sh;
      d.div_num = {q.div_num[62:0], 1'b0};
      d.div_quo = quo_fin;
      d.div_cnt = q.div_cnt + 6'h01;
      if (q.div_cnt == 6'h3f) begin
        d.div_st = esd_pkg::ESD_DIV_IDLE;
        d.speed  = q.div_neg ? 32'(-sat_mag) : sat_mag;
      end
    end

    if (pos_valid_i && !q.boot) begin
      d.life     = q.life + 32'h0000_0001;
      d.tstamp   = q.us_cnt;
      d.last_pos = pos_value_i;
      d.have_pos = 1'b1;
      if (spd_en && q.have_pos) begin
        d.sum     = new_sum;
        d.ptr     = (q.ptr == 10'(len - 11'd1)) ? 10'h000 : q.ptr + 10'h001;
        d.fill    = (q.fill == len) ? q.fill : q.fill + 11'h001;
        d.div_st  = esd_pkg::ESD_DIV_RUN;
        d.div_num = 64'(mag) * 64'(scale);
        d.div_den = (q.speed_unit == `ESD_UNIT_RPM && steps_per_rev_i != 32'h0)
                    ? 43'(len) * 43'(steps_per_rev_i)
                    : 43'(len);
        d.div_neg = new_sum[47];
        d.div_quo = 64'h0;
        d.div_rem = 44'h0;
        d.div_cnt = 6'h00;
      end
    end

    if (!spd_en) begin
      d.speed  = 32'h0000_0000;
      d.sum    = 48'h0;
      d.ptr    = 10'h000;
      d.fill   = 11'h000;
      d.div_st = esd_pkg::ESD_DIV_IDLE;
    end

    // SDO service: one request in, one answer out.
    if (rx_take) begin
      d.tx_valid = 1'b1;
      d.tx_frame = sdo_frame(node_id_i, `ESD_RSP_DOWNLOAD, rx_idx, rx_sub, 32'h0);
      if (!ob_exists) begin
        ab_code = `ESD_AB_NO_OBJ;
      end else if (!ob_sub_ok) begin
        ab_code = `ESD_AB_NO_SUB;
      end else if (rx_cmd == `ESD_CMD_UPLOAD) begin
        if (!ob_rd) begin
          ab_code = `ESD_AB_WR_ONLY;
        end else begin
          d.tx_frame = sdo_frame(node_id_i,
                                 (ob_size == 2'd0) ? `ESD_RSP_UP1 :
                                 (ob_size == 2'd1) ? `ESD_RSP_UP2 : `ESD_RSP_UP4,
                                 rx_idx, rx_sub, ob_val);
        end
      end else if (rx_cmd[7:5] == 3'b001 && rx_cmd[1]) begin
        if (!ob_wr) begin
          ab_code = `ESD_AB_RD_ONLY;
        end else begin
          case ({rx_idx, rx_sub})
            {`ESD_IDX_SPEED_CTRL, 8'h01}: begin
              if (rx_wd[7:0] <= `ESD_UNIT_RPM) begin
                d.speed_unit = rx_wd[7:0];
              end else begin
                ab_code = `ESD_AB_RANGE;
              end
            end
            {`ESD_IDX_SPEED_CTRL, 8'h02}: begin
              if (rx_wd[7:0] <= `ESD_FILT_MAX) begin
                // A new length invalidates the history; restart the average.
                d.speed_filt = rx_wd[7:0];
                d.sum        = 48'h0;
                d.ptr        = 10'h000;
                d.fill       = 11'h000;
              end else begin
                ab_code = `ESD_AB_RANGE;
              end
            end
            {`ESD_IDX_ACCEL_CTRL, 8'h01}: d.acc_en   = rx_wd[7:0];
            {`ESD_IDX_ACCEL_CTRL, 8'h02}: d.acc_mode = rx_wd[7:0];
            {`ESD_IDX_COMPAT, 8'h01}: begin
              d.unlock_sig = rx_wd;
              d.unlocked   = rx_wd == `ESD_UNLOCK_SIG;
            end
            {`ESD_IDX_COMPAT, 8'h02}: begin
              if (!q.unlocked) begin
                ab_code = `ESD_AB_STORE;
              end else if (rx_wd[31:8] == `ESD_COMPAT_SIG && rx_wd[7:1] == 7'h00) begin
                d.compat_mode = rx_wd;
                d.legacy      = rx_wd[0];
                d.unlocked    = 1'b0;
              end else begin
                ab_code = `ESD_AB_RANGE;
              end
            end
            {`ESD_IDX_BOOT, 8'h00}: begin
              if (rx_wd == `ESD_BOOT_CODE) begin
                d.boot      = 1'b1;
                d.erase_req = 1'b1;
                d.reset_req = 1'b1;
              end else begin
                ab_code = `ESD_AB_STORE;
              end
            end
            {`ESD_IDX_PPR, 8'h00}: begin
              if (rx_wd[15:0] != 16'h0 && rx_wd[15:0] <= `ESD_PPR_MAX) begin
                d.ppr_set = rx_wd[15:0];
              end else begin
                ab_code = `ESD_AB_RANGE;
              end
            end
            default: begin
              ab_code = `ESD_AB_NO_SUB;
            end
          endcase
        end
      end else begin
        ab_code = `ESD_AB_CMD;
      end
      if (ab_code != 32'h0000_0000) begin
        d.tx_frame = sdo_frame(node_id_i, `ESD_RSP_ABORT, rx_idx, rx_sub, ab_code);
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      q            <= '0;
      q.speed_unit <= `ESD_UNIT_OFF;
      q.ppr_set    <= `ESD_PPR_RST;
      q.ppr_act    <= `ESD_PPR_RST;
      q.life       <= 32'h0000_0000;
      q.div_st     <= esd_pkg::ESD_DIV_IDLE;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign tx_valid_o           = q.tx_valid;
  assign tx_frame_o           = q.tx_frame;
  assign speed_value_o        = q.speed;
  assign life_count_o         = q.life;
  assign time_stamp_o         = q.tstamp;
  assign pulses_per_rev_o     = q.ppr_act;
  assign legacy_compat_mode_o = q.legacy;
  assign boot_active_o        = q.boot;
  assign encoder_run_o        = !q.boot;
  assign erase_req_o          = q.erase_req;
  assign reset_req_o          = q.reset_req;
  assign boot_node_id_o       = `ESD_BOOT_NODE;
  assign boot_bitrate_o       = `ESD_BOOT_BITRATE;

endmodule

// file: esd_objects_tail_note_unused.sv
// Empty unit with no logic.

// file: esd_objects_sva.sv
// Concurrent checks on the ports of the speed and diagnostic object block.
`timescale 1ns/1ps
module esd_objects_sva (
  // Clock and reset
  input wire logic                   sys_clk_i,
  input wire logic                   rst_n_i,
  // Requests and answers
  input wire logic [6:0]             node_id_i,
  input wire logic                   nmt_reset_i,
  input wire logic                   rx_valid_i,
  input wire esd_pkg::esd_frame_type rx_frame_i,
  input wire logic                   rx_ready_o,
  input wire logic                   tx_valid_o,
  input wire esd_pkg::esd_frame_type tx_frame_o,
  input wire logic                   tx_ready_i,
  // Process values
  input wire logic                   pos_valid_i,
  input wire logic [31:0]            speed_value_o,
  input wire logic [31:0]            life_count_o,
  input wire logic [31:0]            time_stamp_o,
  input wire logic [15:0]            pulses_per_rev_o,
  input wire logic                   legacy_compat_mode_o,
  // Bootloader
  input wire logic                   boot_active_o,
  input wire logic                   encoder_run_o,
  input wire logic                   erase_req_o,
  input wire logic                   reset_req_o,
  input wire logic [6:0]             boot_node_id_o,
  input wire logic [2:0]             boot_bitrate_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic take;
  assign take = rx_valid_i && rx_ready_o && rx_frame_i.dlc == 4'h8
                && rx_frame_i.id == 11'h600 + {4'h0, node_id_i};
  property p_answer;
    take |=> tx_valid_o && tx_frame_o.id == 11'h580 + {4'h0, node_id_i};
  endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_hold;
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_frame_o);
  endproperty
  a_hold: assert property (p_hold) else $error("answer dropped early");
  property p_life;
    pos_valid_i && !boot_active_o |=> life_count_o == $past(life_count_o) + 32'h1;
  endproperty
  a_life: assert property (p_life) else $error("life not stepped");
  property p_life_idle;
    !pos_valid_i |=> $stable(life_count_o);
  endproperty
  a_life_idle: assert property (p_life_idle) else $error("life counter moved");
  property p_stamp;
    !pos_valid_i |=> $stable(time_stamp_o);
  endproperty
  a_stamp: assert property (p_stamp) else $error("time stamp moved");
  property p_spd_rst;
    $rose(rst_n_i) |-> speed_value_o == 32'h0;
  endproperty
  a_spd_rst: assert property (p_spd_rst) else $error("speed not zero");
  property p_ppr;
    !nmt_reset_i |=> $stable(pulses_per_rev_o);
  endproperty
  a_ppr: assert property (p_ppr) else $error("pulse count changed early");
  property p_ppr_rng;
    pulses_per_rev_o inside {[16'h0001:16'h4000]};
  endproperty
  a_ppr_rng: assert property (p_ppr_rng) else $error("pulse count out of range");
  property p_legacy;
    take && legacy_compat_mode_o && !boot_active_o && rx_frame_i.data[2] == 8'h30
    && rx_frame_i.data[1] == 8'h40 |=> tx_frame_o.data[0] == 8'h80;
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy not aborted");
  property p_boot;
    $rose(boot_active_o) |-> erase_req_o && reset_req_o;
  endproperty
  a_boot: assert property (p_boot) else $error("boot entry without erase");
  property p_boot_lvl;
    boot_active_o |=> boot_active_o && !encoder_run_o && boot_node_id_o == 7'h01
    && boot_bitrate_o == 3'h3;
  endproperty
  a_boot_lvl: assert property (p_boot_lvl) else $error("boot state wrong");
  c_legacy: cover property ($rose(legacy_compat_mode_o));
  c_boot: cover property ($rose(boot_active_o));
  c_speed: cover property (speed_value_o != 32'h0);
endmodule

bind esd_objects esd_objects_sva esd_objects_sva_i (.*);

// file: esd_master_model.sv
// Network master model issuing expedited SDO requests and consuming answers.
`timescale 1ns/1ps
module esd_master_model (
  // Clock and node
  input  wire logic                   clk_i,
  input  wire logic [6:0]             node_i,
  // Requests
  output esd_pkg::esd_frame_type      rx_frame_o,
  output logic                        rx_valid_o,
  input  wire logic                   rx_ready_i,
  // Answers
  input  wire esd_pkg::esd_frame_type tx_frame_i,
  input  wire logic                   tx_valid_i,
  output logic                        tx_ready_o
);
  logic timed_out;
  initial begin
    rx_frame_o = '0;
    rx_valid_o = 1'b0;
    tx_ready_o = 1'b0;
    timed_out = 1'b0;
  end
  task automatic sdo(input logic [7:0] c, input logic [15:0] ix, input logic [7:0] sb,
                     input logic [31:0] v, input int stall, output esd_pkg::esd_frame_type r);
    int n;
    @(negedge clk_i);
    rx_frame_o = {11'h600 + {4'h0, node_i}, 4'h8, v, sb, ix, c};
    rx_valid_o = 1'b1;
    if (!rx_ready_i) timed_out = 1'b1;
    @(negedge clk_i);
    rx_valid_o = 1'b0;
    rx_frame_o.data = ~rx_frame_o.data;
    n = 0;
    while (!tx_valid_i && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    if (!tx_valid_i) timed_out = 1'b1;
    r = tx_frame_i;
    repeat (stall) @(negedge clk_i);
    tx_ready_o = 1'b1;
    @(negedge clk_i);
    tx_ready_o = 1'b0;
  endtask
endmodule

// file: tb_top.sv
// Self-checking bench for the speed and diagnostic object block.
`timescale 1ns/1ps
`include "esd_defs.svh"
module tb_top;
  logic sys_clk_i, rst_n_i, nmt_reset_i, rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i;
  logic pos_valid_i, legacy_compat_mode_o, boot_active_o, encoder_run_o, erase_req_o;
  logic reset_req_o;
  logic [31:0] pos_value_i, steps_per_rev_i, speed_value_o, life_count_o, time_stamp_o, t1;
  logic [15:0] pulses_per_rev_o;
  logic [6:0] node_id_i, boot_node_id_o;
  logic [2:0] boot_bitrate_o;
  esd_pkg::esd_frame_type rx_frame_i, tx_frame_o;
  int fail_count, tests_run;
  esd_objects esd_objects_i (.*);
  esd_master_model esd_master_model_i (.clk_i(sys_clk_i), .node_i(node_id_i),
    .rx_frame_o(rx_frame_i), .rx_valid_o(rx_valid_i), .rx_ready_i(rx_ready_o),
    .tx_frame_i(tx_frame_o), .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Stall before taking the answer varies with the index to exercise slow masters.
  task automatic xf(input logic [7:0] c, input logic [15:0] ix, input logic [7:0] sb,
                    input logic [31:0] v, input logic [7:0] ec, input logic [31:0] ev);
    esd_pkg::esd_frame_type r;
    esd_master_model_i.sdo(c, ix, sb, v, ix[1:0], r);
    if (esd_master_model_i.timed_out) begin
      fail_count++;
      stop_test();
    end
    chk("answer command", r.data[0], ec);
    chk("answer value", r.data[7:4], ev);
  endtask
  task automatic pls(input logic [31:0] v);
    @(negedge sys_clk_i);
    pos_valid_i = 1'b1;
    pos_value_i = v;
    @(negedge sys_clk_i);
    pos_valid_i = 1'b0;
    repeat (98) @(negedge sys_clk_i);
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    fail_count++;
    stop_test();
  end
  initial begin
    rst_n_i = 1'b0;
    nmt_reset_i = 1'b0;
    node_id_i = 7'h05;
    pos_valid_i = 1'b0;
    pos_value_i = 32'h0;
    steps_per_rev_i = 32'd1000;
    fail_count = 0;
    tests_run = 0;
    repeat (12) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    xf(8'h40, 16'h3010, 8'h00, 0, 8'h4f, 32'h2);
    xf(8'h40, 16'h3010, 8'h01, 0, 8'h4f, 32'h0);
    xf(8'h40, 16'h3010, 8'h02, 0, 8'h4f, 32'h0);
    xf(8'h40, 16'h3020, 8'h00, 0, 8'h4f, 32'h2);
    xf(8'h40, 16'h3021, 8'h00, 0, 8'h43, 32'h0);
    xf(8'h40, 16'h4010, 8'h00, 0, 8'h4b, 32'h400);
    $display("Test reset values done");
    for (int f = 3; f >= 0; f--)
      xf(8'h22, 16'h3010, 8'h02, f, f > 2 ? 8'h80 : 8'h60, f > 2 ? `ESD_AB_RANGE : 0);
    for (int u = 4; u >= 1; u--)
      xf(8'h22, 16'h3010, 8'h01, u, u > 2 ? 8'h80 : 8'h60, u > 2 ? `ESD_AB_RANGE : 0);
    for (int i = 0; i < 12; i++) begin
      t1 = time_stamp_o;
      pls(i * 5);
    end
    chk("time stamp step", {31'h0, (time_stamp_o - t1) inside {32'd2, 32'd3}}, 1);
    chk("life count", life_count_o, 12);
    chk("speed steps", speed_value_o, 5000);
    xf(8'h22, 16'h3010, 8'h01, 2, 8'h60, 0);
    pls(60);
    chk("speed rpm", speed_value_o, 300);
    xf(8'h22, 16'h3010, 8'h01, 0, 8'h60, 0);
    pls(65);
    chk("speed off", speed_value_o, 0);
    xf(8'h40, 16'h3011, 8'h00, 0, 8'h43, 0);
    xf(8'h22, 16'h3011, 8'h00, 7, 8'h80, `ESD_AB_RD_ONLY);
    xf(8'h22, 16'h3020, 8'h01, 1, 8'h60, 0);
    xf(8'h40, 16'h3020, 8'h01, 0, 8'h4f, 1);
    $display("Test speed and acceleration done");
    xf(8'h22, 16'h3030, 8'h02, 32'h42434d01, 8'h80, `ESD_AB_STORE);
    chk("legacy locked", legacy_compat_mode_o, 0);
    xf(8'h22, 16'h3030, 8'h01, 32'h4d425954, 8'h60, 0);
    xf(8'h22, 16'h3030, 8'h02, 32'h42434d01, 8'h60, 0);
    chk("legacy on", legacy_compat_mode_o, 1);
    xf(8'h40, 16'h3040, 8'h00, 0, 8'h80, `ESD_AB_NO_OBJ);
    xf(8'h40, 16'h3050, 8'h00, 0, 8'h80, `ESD_AB_NO_OBJ);
    xf(8'h40, 16'h3010, 8'h00, 0, 8'h4f, 2);
    xf(8'h22, 16'h3030, 8'h01, 32'h4d425954, 8'h60, 0);
    xf(8'h22, 16'h3030, 8'h02, 32'h42434d02, 8'h80, `ESD_AB_RANGE);
    xf(8'h22, 16'h3030, 8'h02, 32'h42434d00, 8'h60, 0);
    chk("legacy off", legacy_compat_mode_o, 0);
    $display("Test compatibility mode done");
    xf(8'h22, 16'h4010, 8'h00, 32'h4001, 8'h80, `ESD_AB_RANGE);
    xf(8'h22, 16'h4010, 8'h00, 32'h4000, 8'h60, 0);
    xf(8'h40, 16'h4010, 8'h00, 0, 8'h4b, 32'h4000);
    chk("pulses before nmt", pulses_per_rev_o, 32'h400);
    @(negedge sys_clk_i);
    nmt_reset_i = 1'b1;
    @(negedge sys_clk_i);
    nmt_reset_i = 1'b0;
    chk("pulses after nmt", pulses_per_rev_o, 32'h4000);
    $display("Test pulse setting done");
    xf(8'h40, 16'h4000, 8'h00, 0, 8'h80, `ESD_AB_WR_ONLY);
    xf(8'h22, 16'h4000, 8'h00, 0, 8'h80, `ESD_AB_STORE);
    chk("boot idle", boot_active_o, 0);
    xf(8'h22, 16'h4000, 8'h00, `ESD_BOOT_CODE, 8'h60, 0);
    chk("boot on", boot_active_o, 1);
    chk("encoder run", encoder_run_o, 0);
    chk("boot node", boot_node_id_o, 1);
    chk("boot rate", boot_bitrate_o, 3);
    xf(8'h40, 16'h3010, 8'h00, 0, 8'h80, `ESD_AB_NO_OBJ);
    pls(99);
    chk("life frozen", life_count_o, 14);
    $display("Test bootloader done");
    stop_test();
  end
endmodule
